// ===== rtl/i2cmsc_pkg.sv
// shared constants and types of the two-wire sequence control block
package i2cmsc_pkg;

    localparam int          APB_AW      = 8;

    // register byte offsets
    localparam logic [7:0]  CTL2_OFF    = 8'h00;
    localparam logic [7:0]  TXD_OFF     = 8'h04;
    localparam logic [7:0]  RXD_OFF     = 8'h08;
    localparam logic [7:0]  CFG_OFF     = 8'h0C;

    // serial_port_control_two fields
    localparam int          GENERAL_CALL_ENABLE_BIT    = 7;
    localparam int          ACKST_BIT   = 6;
    localparam int          ACK_DATA_VALUE_BIT   = 5;
    localparam int          ACK_SEQUENCE_ENABLE_BIT   = 4;
    localparam int          RECEIVE_ENABLE_BIT    = 3;
    localparam int          PEN_BIT     = 2;
    localparam int          REPEATED_START_ENABLE_BIT    = 1;
    localparam int          SEN_BIT     = 0;
    localparam logic [7:0]  CTL2_RST    = 8'h00;

    // configuration and status fields
    localparam int          TGT_BIT     = 0;
    localparam int          GCSEEN_BIT  = 1;
    localparam int          BUSY_BIT    = 2;

    localparam logic [7:0]  GC_ADDR     = 8'h00;

    // one code serves as command and as engine state
    typedef enum logic [6:0] {
        OP_IDLE   = 7'h01,
        OP_START  = 7'h02,
        OP_RSTART = 7'h04,
        OP_STOP   = 7'h08,
        OP_ACK    = 7'h10,
        OP_RX     = 7'h20,
        OP_TX     = 7'h40
    } i2cmsc_op_e;

    // line pull-low patterns, bit n is quarter n of a bit time
    localparam logic [3:0]  SCL_START   = 4'h8;
    localparam logic [3:0]  SDA_START   = 4'hC;
    localparam logic [3:0]  SCL_RSTART  = 4'h9;
    localparam logic [3:0]  SDA_RSTART  = 4'hC;
    localparam logic [3:0]  SCL_STOP    = 4'h1;
    localparam logic [3:0]  SDA_STOP    = 4'h3;
    localparam logic [3:0]  SCL_DATA    = 4'h9;
    localparam logic [1:0]  SAMPLE_Q    = 2'h1;
    localparam logic [1:0]  LAST_Q      = 2'h3;

    localparam logic [3:0]  BITS_TX     = 4'h9;
    localparam logic [3:0]  BITS_RX     = 4'h8;
    localparam logic [3:0]  BITS_ONE    = 4'h1;
    localparam logic [3:0]  ACK_BITNO   = 4'h8;

    // quarter of a 100 kHz bus clock, least time, on the link clock
    localparam int          QTR_NS      = 2500;
    localparam int          LINK_CLK_NS = 64;
    localparam int          QTR_CYC     = (QTR_NS + LINK_CLK_NS - 1) / LINK_CLK_NS;

endpackage

// ===== rtl/i2cmsc_xfer_if.sv
// command and result handshake between register side and link engine
interface i2cmsc_xfer_if import i2cmsc_pkg::*; ();
    logic        req_t;
    i2cmsc_op_e  cmd;
    logic [7:0]  tx_byte;
    logic        ack_val;
    logic        target_mode;
    logic        general_call_enable;
    logic        done_t;
    logic [7:0]  rx_byte;
    logic        ack_nack;
    logic        gc_t;

    modport ctl  (output req_t, cmd, tx_byte, ack_val, target_mode, general_call_enable,
                  input  done_t, rx_byte, ack_nack, gc_t);
    modport link (input  req_t, cmd, tx_byte, ack_val, target_mode, general_call_enable,
                  output done_t, rx_byte, ack_nack, gc_t);
endinterface

// ===== rtl/i2cmsc_link.sv
// link-clock engine: bus sequences, byte shifting and general-call watch
module i2cmsc_link import i2cmsc_pkg::*; #(
    parameter int QTR_CYCLES = QTR_CYC
) (
    input  wire logic   link_clk,
    input  wire logic   rst,
    i2cmsc_xfer_if.link xf,
    input  wire logic   sda_i,
    output logic        sda_o,
    output logic        sda_oe,
    input  wire logic   scl_i,
    output logic        scl_o,
    output logic        scl_oe
);
    localparam int TW = $clog2(QTR_CYCLES + 1);

    logic          lrst_m, lrst;
    logic          req_m, req_s, tgt_m, tgt_s, general_call_enable_m, general_call_enable_s;
    logic          sda_m, sda_s, scl_m, scl_s, sda_d, scl_d;
    logic          req_seen_r, done_t_r, gc_t_r, ack_nack_r, listen_r;
    i2cmsc_op_e    op_r;
    logic [1:0]    q_r;
    logic [3:0]    bit_r, lcnt_r;
    logic [TW-1:0] tick_r;
    logic [7:0]    shift_r, rx_byte_r, lsh_r;

    // reset asserts at once, releases in step with the link clock
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            lrst_m <= 1'b1;
            lrst   <= 1'b1;
        end else begin
            lrst_m <= 1'b0;
            lrst   <= lrst_m;
        end
    end

    always_ff @(posedge link_clk or posedge lrst) begin
        if (lrst) begin
            {req_m, req_s, tgt_m, tgt_s, general_call_enable_m, general_call_enable_s} <= 6'h00;
            {sda_m, sda_s, scl_m, scl_s, sda_d, scl_d}   <= 6'h3F;
        end else begin
            {req_m, tgt_m, general_call_enable_m, sda_m, scl_m} <= {xf.req_t, xf.target_mode, xf.general_call_enable,
                                                     sda_i, scl_i};
            {req_s, tgt_s, general_call_enable_s, sda_s, scl_s} <= {req_m, tgt_m, general_call_enable_m, sda_m, scl_m};
            {sda_d, scl_d}                       <= {sda_s, scl_s};
        end
    end

    wire       new_req   = (req_s != req_seen_r) && (op_r == OP_IDLE);
    wire       tx_data   = (op_r == OP_TX) && (bit_r < ACK_BITNO);
    wire       cur_bit   = (op_r == OP_ACK) ? xf.ack_val : (tx_data ? shift_r[7] : 1'b1);
    wire [3:0] scl_pat   = (op_r == OP_START)  ? SCL_START  :
                           (op_r == OP_RSTART) ? SCL_RSTART :
                           (op_r == OP_STOP)   ? SCL_STOP   :
                           (op_r == OP_IDLE)   ? 4'h0       : SCL_DATA;
    wire [3:0] sda_pat   = (op_r == OP_START)  ? SDA_START  :
                           (op_r == OP_RSTART) ? SDA_RSTART :
                           (op_r == OP_STOP)   ? SDA_STOP   :
                           (op_r == OP_IDLE)   ? 4'h0       : {4{~cur_bit}};
    wire [3:0] nbits     = (op_r == OP_TX) ? BITS_TX : ((op_r == OP_RX) ? BITS_RX : BITS_ONE);
    wire       scl_low   = scl_pat[q_r];
    wire       sda_low   = sda_pat[q_r];
    // a target holding the clock low stretches the quarter
    wire       stretch   = ~scl_low & ~scl_s & (op_r != OP_IDLE);
    wire       tick_end  = (tick_r == TW'(QTR_CYCLES - 1)) && ~stretch;
    wire       last_q    = (q_r == LAST_Q);
    wire       sample    = tick_end && (q_r == SAMPLE_Q);
    wire       finish    = tick_end && last_q && (bit_r == nbits - BITS_ONE);
    wire       start_det = scl_s & scl_d & sda_d & ~sda_s;
    wire       stop_det  = scl_s & scl_d & ~sda_d & sda_s;
    wire       scl_rise  = scl_s & ~scl_d;
    wire [7:0] lsh_nxt   = {lsh_r[6:0], sda_s};

    always_ff @(posedge link_clk or posedge lrst) begin
        if (lrst) begin
            op_r       <= OP_IDLE;
            req_seen_r <= 1'b0;
            q_r        <= 2'h0;
            bit_r      <= 4'h0;
            tick_r     <= '0;
        end else if (new_req) begin
            op_r       <= xf.cmd;
            req_seen_r <= req_s;
            q_r        <= 2'h0;
            bit_r      <= 4'h0;
            tick_r     <= '0;
        end else if (op_r != OP_IDLE) begin
            tick_r <= tick_end ? '0 : (stretch ? tick_r : tick_r + TW'(1));
            q_r    <= tick_end ? q_r + 2'h1 : q_r;
            bit_r  <= (tick_end && last_q) ? bit_r + 4'h1 : bit_r;
            op_r   <= finish ? OP_IDLE : op_r;
        end
    end

    // ack sampled in the high phase of the ninth clock
    always_ff @(posedge link_clk or posedge lrst) begin
        if (lrst) begin
            shift_r    <= 8'h00;
            rx_byte_r  <= 8'h00;
            ack_nack_r <= 1'b0;
            done_t_r   <= 1'b0;
        end else begin
            if (new_req)
                shift_r <= xf.tx_byte;
            else if (tx_data && tick_end && last_q)
                shift_r <= {shift_r[6:0], 1'b0};
            else if (sample && op_r == OP_RX)
                shift_r <= {shift_r[6:0], sda_s};
            if (sample && op_r == OP_TX && bit_r == ACK_BITNO)
                ack_nack_r <= sda_s;
            if (finish && op_r == OP_RX)
                rx_byte_r <= shift_r;
            if (finish)
                done_t_r <= ~done_t_r;
        end
    end

    always_ff @(posedge link_clk or posedge lrst) begin
        if (lrst) begin
            listen_r <= 1'b0;
            lcnt_r   <= 4'h0;
            lsh_r    <= 8'h00;
            gc_t_r   <= 1'b0;
        end else if (~tgt_s || stop_det) begin
            listen_r <= 1'b0;
        end else if (start_det) begin
            listen_r <= 1'b1;
            lcnt_r   <= 4'h0;
        end else if (listen_r && scl_rise) begin
            lsh_r    <= lsh_nxt;
            lcnt_r   <= lcnt_r + 4'h1;
            listen_r <= (lcnt_r != BITS_RX - BITS_ONE);
            if (lcnt_r == BITS_RX - BITS_ONE && lsh_nxt == GC_ADDR && general_call_enable_s)
                gc_t_r <= ~gc_t_r;
        end
    end

    // stop leaves lines released
    // open drain: enable high pulls the line low
    // lines stay parked between commands, so the clock is held low after a
    // start or a byte and no false stop appears on the bus
    always_ff @(posedge link_clk or posedge lrst) begin
        if (lrst) begin
            {sda_oe, scl_oe, sda_o, scl_o} <= 4'h0;
        end else begin
            sda_oe <= (op_r == OP_IDLE) ? sda_oe : sda_low;
            scl_oe <= (op_r == OP_IDLE) ? scl_oe : scl_low;
            sda_o  <= 1'b0;
            scl_o  <= 1'b0;
        end
    end

    assign xf.done_t   = done_t_r;
    assign xf.rx_byte  = rx_byte_r;
    assign xf.ack_nack = ack_nack_r;
    assign xf.gc_t     = gc_t_r;

    ack_drive_a: assert property (@(posedge link_clk) disable iff (lrst)
        (op_r == OP_ACK) |=> (sda_oe == !$past(xf.ack_val)))
        else $error("ack bit not driven with chosen value");
    ack_sample_a: assert property (@(posedge link_clk) disable iff (lrst)
        (sample && op_r == OP_TX && bit_r == ACK_BITNO) |=> (ack_nack_r == $past(sda_s)))
        else $error("ack status not taken at ninth clock");
    start_shape_a: assert property (@(posedge link_clk) disable iff (lrst)
        (op_r == OP_START && q_r == 2'h2) |=> (sda_oe && !scl_oe))
        else $error("start does not pull data low with clock high");
    stop_release_a: assert property (@(posedge link_clk) disable iff (lrst)
        (finish && op_r == OP_STOP) |=> (!scl_oe && !sda_oe)[*2])
        else $error("stop does not release the lines");
endmodule

// ===== rtl/i2cmsc_top.sv
// register side and apb slave of the two-wire sequence control block
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - general call in target mode raises event
// - ack status one means not acknowledged
// - receiver drives chosen ack value
// - ack sequence enable sends ack, self-clears
// - receive enable clocks in one byte
// - stop enable makes Stop, self-clears
// - repeated start enable makes Repeated Start, self-clears
// - start enable makes Start, self-clears
//
// Register access over APB and the address map were left to the implementer.
module i2cmsc_top import i2cmsc_pkg::*; #(
    parameter int QTR_CYCLES = QTR_CYC
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [APB_AW-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              link_clk,
    input  wire logic              sda_i,
    output logic                   sda_o,
    output logic                   sda_oe,
    input  wire logic              scl_i,
    output logic                   scl_o,
    output logic                   scl_oe,
    output logic                   gc_event
);

    //////////////////////////////////////////////////////////////////////////
    // register decode

    // one-hot select: control, transmit, receive, configuration
    function automatic logic [3:0] reg_sel(input logic [APB_AW-1:0] a);
        reg_sel = {a == CFG_OFF, a == RXD_OFF, a == TXD_OFF, a == CTL2_OFF};
    endfunction

    i2cmsc_xfer_if xf ();

    logic        pready_r;
    logic [31:0] prdata_r;
    logic        pslverr_r;
    logic        general_call_enable_r, ack_data_value_r, ack_status_r, tgt_r, gc_seen_r, busy_r;
    logic [4:0]  seq_r;
    logic [7:0]  tx_data_r, rx_data_r;
    logic        ack_lat_r, req_t_r;
    i2cmsc_op_e  cmd_r;
    logic        done_m, done_s, done_d, gc_m, gc_s, gc_d;

    wire [3:0]  wsel     = reg_sel(paddr);
    wire        setup    = psel & penable & ~pready_r;
    wire        wr       = psel & penable & pready_r & pwrite;
    wire        wr_ctl   = wr & wsel[0];
    wire        wr_txd   = wr & wsel[1];
    wire        wr_cfg   = wr & wsel[3];
    wire [7:0]  ctl_rd   = {general_call_enable_r, ack_status_r, ack_data_value_r, seq_r};
    wire [7:0]  cfg_rd   = {5'h00, busy_r, gc_seen_r, tgt_r};
    wire [7:0]  rd_byte  = wsel[0] ? ctl_rd    :
                           wsel[1] ? tx_data_r :
                           wsel[2] ? rx_data_r :
                           wsel[3] ? cfg_rd    : 8'h00;

    //////////////////////////////////////////////////////////////////////////
    // sequence launch

    // new sequences only from an idle controller; writing zero clears nothing
    wire        can_go   = ~busy_r & ~tgt_r;
    wire [4:0]  new_set  = wr_ctl ? pwdata[4:0] : 5'h00;
    // several bits at once: the lowest one wins, the rest are dropped
    wire [4:0]  pick     = new_set & (~new_set + 5'h01);
    wire        go_seq   = can_go & (|new_set);
    wire        go_tx    = can_go & wr_txd;
    wire        done_evt = done_s ^ done_d;
    wire        gc_evt   = gc_s ^ gc_d;
    wire        gc_clr   = wr_cfg & pwdata[GCSEEN_BIT];
    // the data value written together with the enable bit is the one sent
    wire        ack_data_value_now = wr_ctl ? pwdata[ACK_DATA_VALUE_BIT] : ack_data_value_r;

    wire i2cmsc_op_e seq_op = pick[SEN_BIT]   ? OP_START  :
                              pick[REPEATED_START_ENABLE_BIT]  ? OP_RSTART :
                              pick[PEN_BIT]   ? OP_STOP   :
                              pick[RECEIVE_ENABLE_BIT]  ? OP_RX     : OP_ACK;

    //////////////////////////////////////////////////////////////////////////
    // apb slave, one wait state

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= setup;
            prdata_r  <= (setup & ~pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            pslverr_r <= setup & ~(|wsel);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // control register

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            general_call_enable_r  <= CTL2_RST[GENERAL_CALL_ENABLE_BIT];
            ack_data_value_r <= CTL2_RST[ACK_DATA_VALUE_BIT];
            tgt_r   <= 1'b0;
        end else begin
            if (wr_ctl) begin
                general_call_enable_r  <= pwdata[GENERAL_CALL_ENABLE_BIT];
                ack_data_value_r <= pwdata[ACK_DATA_VALUE_BIT];
            end
            if (wr_cfg)
                tgt_r <= pwdata[TGT_BIT];
        end
    end

    // one-shot bits set by software, cleared when the link is done
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seq_r  <= CTL2_RST[4:0];
            busy_r <= 1'b0;
        end else if (go_seq | go_tx) begin
            seq_r  <= go_seq ? pick : 5'h00;
            busy_r <= 1'b1;
        end else if (done_evt) begin
            seq_r  <= 5'h00;
            busy_r <= 1'b0;
        end
    end

    // ack value frozen for the length of the sequence
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            req_t_r   <= 1'b0;
            cmd_r     <= OP_IDLE;
            tx_data_r <= 8'h00;
            ack_lat_r <= 1'b0;
        end else if (go_seq | go_tx) begin
            req_t_r   <= ~req_t_r;
            cmd_r     <= go_seq ? seq_op : OP_TX;
            ack_lat_r <= ack_data_value_now;
            if (go_tx)
                tx_data_r <= pwdata[7:0];
        end
    end

    // result capture when the link reports completion
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_status_r <= CTL2_RST[ACKST_BIT];
            rx_data_r    <= 8'h00;
        end else if (done_evt) begin
            if (cmd_r == OP_TX)
                ack_status_r <= xf.ack_nack;
            if (cmd_r == OP_RX)
                rx_data_r <= xf.rx_byte;
        end
    end

    // sticky general-call flag, a new event beats the clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            gc_seen_r <= 1'b0;
        else
            gc_seen_r <= gc_evt | (gc_seen_r & ~gc_clr);
    end

    //////////////////////////////////////////////////////////////////////////
    // crossings from the link domain; toggles carry the events

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {done_m, done_s, done_d} <= 3'h0;
            {gc_m, gc_s, gc_d}       <= 3'h0;
        end else begin
            {done_m, done_s, done_d} <= {xf.done_t, done_m, done_s};
            {gc_m, gc_s, gc_d}       <= {xf.gc_t, gc_m, gc_s};
        end
    end

    // words reach the link only while its toggle is outstanding, so they are stable
    assign xf.req_t       = req_t_r;
    assign xf.cmd         = cmd_r;
    assign xf.tx_byte     = tx_data_r;
    assign xf.ack_val     = ack_lat_r;
    assign xf.target_mode = tgt_r;
    assign xf.general_call_enable        = general_call_enable_r;

    i2cmsc_link #(
        .QTR_CYCLES (QTR_CYCLES)
    ) u_link (
        .link_clk (link_clk),
        .rst      (rst),
        .xf       (xf),
        .sda_i    (sda_i),
        .sda_o    (sda_o),
        .sda_oe   (sda_oe),
        .scl_i    (scl_i),
        .scl_o    (scl_o),
        .scl_oe   (scl_oe)
    );

    assign prdata   = prdata_r;
    assign pready   = pready_r;
    assign pslverr  = pslverr_r;
    assign gc_event = gc_seen_r;

    //////////////////////////////////////////////////////////////////////////
    // checks

    apb_ready_a: assert property (@(posedge clk) disable iff (rst)
        (psel && penable && !pready_r) |=> pready_r ##1 !pready_r)
        else $error("apb answer not after exactly one wait state");
    start_clr_a: assert property (@(posedge clk) disable iff (rst)
        (done_evt && cmd_r == OP_START) |=> !seq_r[SEN_BIT] && !busy_r)
        else $error("start enable not cleared at completion");
    rstart_clr_a: assert property (@(posedge clk) disable iff (rst)
        (done_evt && cmd_r == OP_RSTART) |=> !seq_r[REPEATED_START_ENABLE_BIT])
        else $error("repeated start enable not cleared at completion");
    stop_clr_a: assert property (@(posedge clk) disable iff (rst)
        (done_evt && cmd_r == OP_STOP) |=> !seq_r[PEN_BIT])
        else $error("stop enable not cleared at completion");
    ack_clr_a: assert property (@(posedge clk) disable iff (rst)
        (done_evt && cmd_r == OP_ACK) |=> !seq_r[ACK_SEQUENCE_ENABLE_BIT])
        else $error("ack sequence enable not cleared at completion");
    rcv_byte_a: assert property (@(posedge clk) disable iff (rst)
        (done_evt && cmd_r == OP_RX) |=> !seq_r[RECEIVE_ENABLE_BIT] && rx_data_r == $past(xf.rx_byte))
        else $error("received byte not captured or receive enable stuck");
    ack_stat_a: assert property (@(posedge clk) disable iff (rst)
        (done_evt && cmd_r == OP_TX) |=> ack_status_r == $past(xf.ack_nack))
        else $error("ack status not updated after a transmitted byte");
    gc_flag_a: assert property (@(posedge clk) disable iff (rst)
        gc_evt |=> gc_seen_r [*2] or (gc_seen_r ##1 $past(gc_clr)))
        else $error("general-call flag lost");
    busy_hold_a: assert property (@(posedge clk) disable iff (rst)
        (busy_r && !done_evt) |=> $stable(cmd_r) && $stable(tx_data_r))
        else $error("command changed while the link is busy");
    refuse_busy_a: assert property (@(posedge clk) disable iff (rst)
        (wr_ctl && busy_r && !done_evt) |=> $stable(seq_r) && busy_r)
        else $error("sequence launched while the link is busy");
    unmapped_a: assert property (@(posedge clk) disable iff (rst)
        (pready_r && !(|wsel)) |-> pslverr_r && prdata_r == 32'h0000_0000)
        else $error("unmapped access not flagged");

    start_cov_c: cover property (@(posedge clk) disable iff (rst)
        go_seq && pick[SEN_BIT] ##[1:1000] done_evt);
    nack_cov_c: cover property (@(posedge clk) disable iff (rst)
        done_evt && cmd_r == OP_TX && xf.ack_nack);
    gc_cov_c: cover property (@(posedge clk) disable iff (rst)
        gc_evt && general_call_enable_r);
    refuse_cov_c: cover property (@(posedge clk) disable iff (rst)
        wr_ctl && busy_r && |pwdata[4:0]);
endmodule

// ===== sim/i2cmsc_bus_model.sv
// far-side bus device: acknowledges, sends one byte, logs bus conditions
module i2cmsc_bus_model (
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic       ack_en,
    input  wire logic       rd_mode,
    input  wire logic [7:0] rd_byte,
    output logic            sda_oe,
    output logic [7:0]      rx_shift,
    output logic            last_bit,
    output int              starts,
    output int              stops
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    initial begin
        sda_oe = 1'b0;
        rx_shift = 8'h00;
        last_bit = 1'b0;
        starts = 0;
        stops = 0;
        cnt = 0;
    end
    // data edge judged 2 ns late against the clock 2 ns before it,
    // so lines that move together count as no condition
    wire #2 sda_l = sda;
    wire #4 scl_l = scl;
    // start or repeated start restarts the bit count
    always @(negedge sda_l) if (scl === 1'b1 && scl_l === 1'b1) begin
        cnt = 0;
        starts++;
    end
    always @(posedge sda_l) if (scl === 1'b1 && scl_l === 1'b1) stops++;
    always @(posedge scl) begin
        last_bit = sda;
        if (cnt < 8) rx_shift = {rx_shift[6:0], sda};
        cnt++;
    end
    // change data only while the clock line is low; a one is a released line
    always @(negedge scl) sda_oe = rd_mode ? (cnt < 8 && !rd_byte[7-cnt]) : (ack_en && cnt == 8);
endmodule

// ===== sim/i2cmsc_tb.sv
// self-checking bench of the two-wire sequence control block
module i2cmsc_tb import i2cmsc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, link_clk = 1'b0, rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, gc_event;
    logic [7:0] paddr = 8'h00, rd_byte = 8'h00, m_rx;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic sda_oe, scl_oe, m_oe, m_last, e;
    logic tb_sda_oe = 1'b0, tb_scl_oe = 1'b0, ack_en = 1'b0, rd_mode = 1'b0;
    int starts, stops, err_total = 0, comparisons = 0;
    // lines are pulled up: any party pulling low wins
    wire sda = ~(sda_oe | m_oe | tb_sda_oe);
    wire scl = ~(scl_oe | tb_scl_oe);
    initial forever #4 clk = ~clk;
    initial begin
        #5;
        forever #32 link_clk = ~link_clk;
    end
    i2cmsc_top #(.QTR_CYCLES(2)) u_i2cmsc_top (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link_clk(link_clk), .sda_i(sda), .sda_o(),
        .sda_oe(sda_oe), .scl_i(scl), .scl_o(), .scl_oe(scl_oe), .gc_event(gc_event));
    i2cmsc_bus_model u_i2cmsc_bus_model (.scl(scl), .sda(sda), .ack_en(ack_en),
        .rd_mode(rd_mode), .rd_byte(rd_byte), .sda_oe(m_oe), .rx_shift(m_rx),
        .last_bit(m_last), .starts(starts), .stops(stops));
    ////////////////////////////////////////////////////////////////////////////
    task results;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            chk(32'h1, 32'h0);
            results();
        end
    endtask
    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    // busy must fall within a bounded number of status polls
    task idle;
        int n;
        n = 0;
        do begin
            apb(1'b0, CFG_OFF, 32'h0);
            n++;
        end while (q[BUSY_BIT] !== 1'b0 && n < 500);
        if (n >= 500) begin
            chk(32'h1, 32'h0);
            results();
        end
    endtask
    task hold;
        repeat (40) @(posedge clk);
    endtask
    // bench acts as another controller: start, address byte, stop
    task frame(input logic [7:0] a);
        tb_sda_oe <= 1'b1;
        hold();
        tb_scl_oe <= 1'b1;
        for (int i = 7; i >= 0; i--) begin
            hold();
            tb_sda_oe <= !a[i];
            hold();
            tb_scl_oe <= 1'b0;
            hold();
            tb_scl_oe <= 1'b1;
        end
        tb_sda_oe <= 1'b1;
        hold();
        tb_scl_oe <= 1'b0;
        hold();
        tb_sda_oe <= 1'b0;
        hold();
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        // the link domain needs the reset across three of its own edges
        repeat (3) @(posedge link_clk);
        @(posedge clk);
        rst <= 1'b0;
        rdchk(CTL2_OFF, 32'h00);
        apb(1'b0, 8'h10, 32'h0);
        chk({q[30:0], e}, 32'h1);
        apb(1'b1, CTL2_OFF, 32'hE0);
        rdchk(CTL2_OFF, 32'hA0);
        apb(1'b1, CTL2_OFF, 32'h00);
        apb(1'b1, CTL2_OFF, 32'h01);
        rdchk(CTL2_OFF, 32'h01);
        idle();
        rdchk(CTL2_OFF, 32'h00);
        chk(starts, 1);
        ack_en <= 1'b1;
        apb(1'b1, TXD_OFF, 32'hA5);
        // stop request while busy is dropped: the stop count below holds only the later stop
        apb(1'b1, CTL2_OFF, 32'h04);
        idle();
        chk(m_rx, 32'hA5);
        rdchk(CTL2_OFF, 32'h00);
        ack_en <= 1'b0;
        apb(1'b1, TXD_OFF, 32'h3C);
        idle();
        rdchk(CTL2_OFF, 32'h40);
        // far side is ready to send before the repeated start ends
        rd_mode <= 1'b1;
        rd_byte <= 8'h96;
        apb(1'b1, CTL2_OFF, 32'h02);
        idle();
        rdchk(CTL2_OFF, 32'h40);
        chk(starts, 2);
        apb(1'b1, CTL2_OFF, 32'h08);
        idle();
        rdchk(RXD_OFF, 32'h96);
        rdchk(CTL2_OFF, 32'h40);
        rd_mode <= 1'b0;
        apb(1'b1, CTL2_OFF, 32'h30);
        idle();
        chk(m_last, 32'h1);
        rdchk(CTL2_OFF, 32'h60);
        apb(1'b1, CTL2_OFF, 32'h10);
        idle();
        chk(m_last, 32'h0);
        apb(1'b1, CTL2_OFF, 32'h04);
        idle();
        rdchk(CTL2_OFF, 32'h40);
        chk(stops, 1);
        chk({scl, sda}, 32'h3);
        apb(1'b1, CFG_OFF, 32'h01);
        apb(1'b1, CTL2_OFF, 32'h80);
        frame(GC_ADDR);
        rdchk(CFG_OFF, 32'h03);
        chk(gc_event, 32'h1);
        apb(1'b1, CFG_OFF, 32'h03);
        apb(1'b1, CTL2_OFF, 32'h00);
        frame(GC_ADDR);
        rdchk(CFG_OFF, 32'h01);
        results();
    end
endmodule
